// File: design/bdrc_pkg.sv
// Constants, types and state layout for the buffer and DMA read commands
// Behaviour
// - Buffer read opcode returns one buffer sector
// - DMA buffer read returns one sector by DMA
// - Data moves as 16-bit words, one per transfer
// - Sector comes from region last buffer-write filled
// - Both media read opcodes accepted, retry bit ignored
// - DMA word moves only while request asserted
// - One interrupt after transfer ends, status ready
// - Uncorrectable error stops at failing sector
// - Sector count of zero means 256 sectors
// - Address clear selects geometric start address
// - Logical bits 0-23 from three address registers
// - Head field supplies logical bits 24-27
// - Count returns sectors left, zero unless error
// - Geometric mode reports last transferred sector
// - Logical mode reports last transferred address bits 0-23
// - Logical mode reports bits 24-27 in head field
package bdrc_pkg;

	// ==========================================
	// Register offsets
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_ERR = 8'h04;
	localparam logic [7:0] OFS_SC = 8'h08;
	localparam logic [7:0] OFS_SN = 8'h0C;
	localparam logic [7:0] OFS_CL = 8'h10;
	localparam logic [7:0] OFS_CH = 8'h14;
	localparam logic [7:0] OFS_DH = 8'h18;
	localparam logic [7:0] OFS_CMD = 8'h1C;

	// ==========================================
	// Opcodes
	localparam logic [7:0] OP_BUF_PIO = 8'hE4;
	localparam logic [7:0] OP_BUF_DMA = 8'hE9;
	localparam logic [7:0] OP_MED_DMA = 8'hC8;
	localparam logic [7:0] OP_RETRY_MASK = 8'hFE;

	// ==========================================
	// Field positions
	localparam int ER_UNC = 6;
	localparam int ER_IDN = 4;
	localparam int ER_ABT = 2;
	localparam int DH_LBA = 2;

	// ==========================================
	// Counts and geometry
	localparam logic [8:0] SECTOR_WORDS = 9'h100;
	localparam logic [8:0] MAX_SECTORS = 9'h100;
	localparam logic [7:0] SECT_PER_TRACK = 8'h3F;
	localparam logic [3:0] LAST_HEAD = 4'hF;
	localparam int FIFO_DEPTH = 8;
	localparam int WORD_W = 16;

	// ==========================================
	// Types
	typedef enum logic [1:0] {BDRC_IDLE, BDRC_BUF, BDRC_MED, BDRC_DRAIN} bdrc_phase_t;

	typedef struct packed {
		logic [3:0] hd;
		logic [7:0] ch;
		logic [7:0] cl;
		logic [7:0] sn;
	} bdrc_addr_t;

	typedef struct packed {
		bdrc_phase_t ph;
		logic pio;
		logic dma;
		logic med;
		logic lba;
		logic [8:0] remain;
		logic [8:0] word;
		bdrc_addr_t cur;
		bdrc_addr_t last;
		bdrc_addr_t tf;
		logic [3:0] dh_hi;
		logic [7:0] sc;
		logic [7:0] err;
		logic intrq;
		logic [7:0] a_ofs;
		logic a_wr;
		logic a_rd;
		logic [255:0][15:0] mem;
	} bdrc_state_t;

endpackage

// File: design/bdrc_top.sv
// Read command interpreter with AHB-Lite task file and word FIFO
`timescale 1ns/100ps

// ==========================================
// Word FIFO
module bdrc_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
		logic [DEPTH-1:0][W-1:0] mem;
	} bdrc_fifo_state_t;

	bdrc_fifo_state_t q;
	bdrc_fifo_state_t s;
	logic [AW:0] cnt;

	assign cnt = q.wr - q.rd;
	assign in_ready = (cnt != FULL_CNT);
	assign out_valid = (q.wr != q.rd);
	assign out_data = q.mem[q.rd[AW-1:0]];

	always_comb begin
		s = q;
		if (in_valid && in_ready) begin
			s.mem[q.wr[AW-1:0]] = in_data;
			s.wr = q.wr + 1'b1;
		end
		if (out_valid && out_ready) begin
			s.rd = q.rd + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= s;
		end
	end
endmodule

// ==========================================
// Command interpreter
module bdrc_top (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic INTRQ,
	output logic DMARQ,
	input wire logic DMACK,
	output logic [15:0] DMA_DATA,
	input wire logic BUF_WR_EN,
	input wire logic [7:0] BUF_WR_ADDR,
	input wire logic [15:0] BUF_WR_DATA,
	output logic MEDIA_REQ,
	output bdrc_pkg::bdrc_addr_t MEDIA_ADDR,
	output logic MEDIA_LBA,
	input wire logic MEDIA_VALID,
	output logic MEDIA_READY,
	input wire logic [15:0] MEDIA_DATA,
	input wire logic MEDIA_UNC,
	input wire logic MEDIA_IDNF
);
	bdrc_pkg::bdrc_state_t q;
	bdrc_pkg::bdrc_state_t s;
	logic push;
	logic [15:0] push_data;
	logic pop;
	logic f_iready;
	logic f_ovalid;
	logic [15:0] f_odata;
	logic drq;
	logic bsy;
	logic [7:0] status;
	logic sel;

	// ==========================================
	// Address step
	function automatic bdrc_pkg::bdrc_addr_t next_addr(
		input bdrc_pkg::bdrc_addr_t a,
		input logic lba
	);
		bdrc_pkg::bdrc_addr_t n;
		n = a;
		if (lba) begin
			n = bdrc_pkg::bdrc_addr_t'(a + 28'h000_0001);
		end else if (a.sn >= bdrc_pkg::SECT_PER_TRACK) begin
			n.sn = 8'h01;
			n.hd = a.hd + 4'h1;
			if (a.hd == bdrc_pkg::LAST_HEAD) begin
				{n.ch, n.cl} = {a.ch, a.cl} + 16'h0001;
			end
		end else begin
			n.sn = a.sn + 8'h01;
		end
		return n;
	endfunction

	bdrc_fifo #(
		.W(bdrc_pkg::WORD_W),
		.DEPTH(bdrc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(MCLK),
		.rst_n(RSTN),
		.in_valid(push),
		.in_ready(f_iready),
		.in_data(push_data),
		.out_valid(f_ovalid),
		.out_ready(pop),
		.out_data(f_odata)
	);

	// ==========================================
	// Status and handshakes
	assign drq = q.pio && f_ovalid;
	assign bsy = (q.ph != bdrc_pkg::BDRC_IDLE) && !drq;
	assign status = {bsy, !bsy, 1'b0, 1'b1, drq, 1'b0, 1'b0, |q.err};
	assign DMARQ = q.dma && (q.ph != bdrc_pkg::BDRC_IDLE) && f_ovalid;
	assign DMA_DATA = f_odata;
	assign pop = (DMARQ && DMACK)
		|| (q.a_rd && q.a_ofs == bdrc_pkg::OFS_DATA && drq);
	assign sel = HSEL && HTRANS[1] && HREADY && (HADDR[31:5] == 27'h000_0000);
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign INTRQ = q.intrq;
	assign MEDIA_REQ = (q.ph == bdrc_pkg::BDRC_MED);
	assign MEDIA_ADDR = q.cur;
	assign MEDIA_LBA = q.lba;
	assign MEDIA_READY = (q.ph == bdrc_pkg::BDRC_MED) && f_iready;

	// ==========================================
	// Read data
	always_comb begin
		HRDATA = 32'h0000_0000;
		if (q.a_rd) begin
			case (q.a_ofs)
				bdrc_pkg::OFS_DATA: HRDATA = {16'h0000, f_odata};
				bdrc_pkg::OFS_ERR: HRDATA = {24'h00_0000, q.err};
				bdrc_pkg::OFS_SC: HRDATA = {24'h00_0000, q.sc};
				bdrc_pkg::OFS_SN: HRDATA = {24'h00_0000, q.tf.sn};
				bdrc_pkg::OFS_CL: HRDATA = {24'h00_0000, q.tf.cl};
				bdrc_pkg::OFS_CH: HRDATA = {24'h00_0000, q.tf.ch};
				bdrc_pkg::OFS_DH: HRDATA = {24'h00_0000, q.dh_hi, q.tf.hd};
				bdrc_pkg::OFS_CMD: HRDATA = {24'h00_0000, status};
				default: HRDATA = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================
	// Next state
	always_comb begin
		s = q;
		push = 1'b0;
		push_data = 16'h0000;

		// Address phase capture
		s.a_wr = sel && HWRITE;
		s.a_rd = sel && !HWRITE;
		s.a_ofs = HADDR[7:0];

		// Buffer fill from the buffer-write path
		if (BUF_WR_EN) begin
			s.mem[BUF_WR_ADDR] = BUF_WR_DATA;
		end

		// Status read acknowledges the interrupt
		if (q.a_rd && q.a_ofs == bdrc_pkg::OFS_CMD) begin
			s.intrq = 1'b0;
		end

		// Task file writes, only while idle
		if (q.a_wr && q.ph == bdrc_pkg::BDRC_IDLE) begin
			case (q.a_ofs)
				bdrc_pkg::OFS_SC: s.sc = HWDATA[7:0];
				bdrc_pkg::OFS_SN: s.tf.sn = HWDATA[7:0];
				bdrc_pkg::OFS_CL: s.tf.cl = HWDATA[7:0];
				bdrc_pkg::OFS_CH: s.tf.ch = HWDATA[7:0];
				bdrc_pkg::OFS_DH: begin
					s.dh_hi = HWDATA[7:4];
					s.tf.hd = HWDATA[3:0];
				end
				bdrc_pkg::OFS_CMD: begin
					s.intrq = 1'b0;
					s.err = 8'h00;
					s.word = 9'h000;
					s.pio = 1'b0;
					s.dma = 1'b0;
					s.med = 1'b0;
					if (HWDATA[7:0] == bdrc_pkg::OP_BUF_PIO) begin
						s.ph = bdrc_pkg::BDRC_BUF;
						s.pio = 1'b1;
					end else if (HWDATA[7:0] == bdrc_pkg::OP_BUF_DMA) begin
						s.ph = bdrc_pkg::BDRC_BUF;
						s.dma = 1'b1;
					end else if ((HWDATA[7:0] & bdrc_pkg::OP_RETRY_MASK)
						== bdrc_pkg::OP_MED_DMA) begin
						s.ph = bdrc_pkg::BDRC_MED;
						s.dma = 1'b1;
						s.med = 1'b1;
						s.lba = q.dh_hi[bdrc_pkg::DH_LBA];
						s.cur = q.tf;
						s.last = q.tf;
						s.remain = (q.sc == 8'h00) ? bdrc_pkg::MAX_SECTORS
							: {1'b0, q.sc};
					end else begin
						s.err[bdrc_pkg::ER_ABT] = 1'b1;
						s.intrq = 1'b1;
					end
				end
				default: s.ph = q.ph;
			endcase
		end

		// Transfer sequencing
		case (q.ph)
			bdrc_pkg::BDRC_BUF: begin
				push = 1'b1;
				push_data = q.mem[q.word[7:0]];
				if (f_iready) begin
					s.word = q.word + 9'h001;
					if (q.word == bdrc_pkg::SECTOR_WORDS - 9'h001) begin
						s.ph = bdrc_pkg::BDRC_DRAIN;
					end
				end
			end
			bdrc_pkg::BDRC_MED: begin
				if (MEDIA_UNC || MEDIA_IDNF) begin
					s.err[bdrc_pkg::ER_UNC] = MEDIA_UNC;
					s.err[bdrc_pkg::ER_IDN] = MEDIA_IDNF;
					s.ph = bdrc_pkg::BDRC_DRAIN;
				end else begin
					push = MEDIA_VALID;
					push_data = MEDIA_DATA;
					if (MEDIA_VALID && f_iready) begin
						s.word = q.word + 9'h001;
						if (q.word == bdrc_pkg::SECTOR_WORDS - 9'h001) begin
							s.word = 9'h000;
							s.remain = q.remain - 9'h001;
							s.last = q.cur;
							s.cur = next_addr(q.cur, q.lba);
							if (q.remain == 9'h001) begin
								s.ph = bdrc_pkg::BDRC_DRAIN;
							end
						end
					end
				end
			end
			bdrc_pkg::BDRC_DRAIN: begin
				if (!f_ovalid) begin
					s.ph = bdrc_pkg::BDRC_IDLE;
					s.intrq = 1'b1;
					s.pio = 1'b0;
					s.dma = 1'b0;
					if (q.med) begin
						s.sc = q.remain[7:0];
						s.tf = q.last;
					end
				end
			end
			bdrc_pkg::BDRC_IDLE: begin
				// Keeps the phase picked by a command write
			end
			default: s.ph = bdrc_pkg::BDRC_IDLE;
		endcase
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			q <= '0;
		end else begin
			q <= s;
		end
	end
endmodule

// File: sim/bdrc_properties.sv
// Checker on the top ports of the read command block
`timescale 1ns/100ps
module bdrc_properties (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic [31:0] HRDATA,
	input wire logic INTRQ,
	input wire logic DMARQ,
	input wire logic DMACK,
	input wire logic [15:0] DMA_DATA,
	input wire logic MEDIA_REQ,
	input wire logic MEDIA_LBA,
	input wire logic MEDIA_READY,
	input wire logic MEDIA_UNC,
	input wire logic MEDIA_IDNF
);
	// ==========
	// Properties
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	a_word_width: assert property (HRDATA[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_hold_word: assert property (DMARQ && !DMACK |=> $stable(DMA_DATA))
		else $error("dma word changed unqualified");
	a_irq_after_end: assert property ((DMARQ || MEDIA_REQ) |-> !INTRQ)
		else $error("interrupt before end");
	a_irq_stays: assert property ($rose(INTRQ) |=> INTRQ)
		else $error("interrupt glitch");
	a_unc_stops: assert property (MEDIA_REQ && MEDIA_UNC |-> ##[1:2] !MEDIA_REQ)
		else $error("read went on after error");
	a_ready_in_read: assert property (MEDIA_READY |-> MEDIA_REQ && !INTRQ)
		else $error("media taken while idle");
	a_mode_stable: assert property (MEDIA_REQ && $past(MEDIA_REQ) |-> $stable(MEDIA_LBA))
		else $error("mode changed in read");
	a_req_ends_irq: assert property ($fell(MEDIA_REQ) |-> !INTRQ)
		else $error("interrupt with media end");
	a_idnf_stops: assert property (MEDIA_REQ && MEDIA_IDNF |=> !MEDIA_REQ)
		else $error("read went on after missing sector");
endmodule

// File: sim/bdrc_dma_host.sv
// Host DMA channel model taking words with random stalls
`timescale 1ns/100ps
module bdrc_dma_host (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic DMARQ,
	output logic DMACK
);
	// ==========
	// Channel
	logic go_q;
	always @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) go_q <= 0;
		else go_q <= ($urandom % 4) != 0;
	end
	assign DMACK = DMARQ && go_q;
endmodule

// File: sim/tb.sv
// Self-checking bench for the read command block
`timescale 1ns/100ps
module tb;
	logic MCLK = 0, RSTN = 0, HSEL = 0, HWRITE = 0, HREADY, rd_ph = 0;
	logic [31:0] HADDR = 0, HWDATA = 0, HRDATA;
	logic [1:0] HTRANS = 0;
	logic [2:0] HSIZE = 3'h2;
	logic HREADYOUT, HRESP, INTRQ, DMARQ, DMACK, MEDIA_REQ, MEDIA_LBA, MEDIA_READY;
	logic BUF_WR_EN = 0, MEDIA_VALID = 0, MEDIA_UNC = 0, MEDIA_IDNF = 0;
	logic [7:0] BUF_WR_ADDR = 0;
	logic [15:0] DMA_DATA, BUF_WR_DATA = 0, MEDIA_DATA = 0;
	logic [15:0] bw [256];
	logic [31:0] eq [$], dq [$];
	bdrc_pkg::bdrc_addr_t MEDIA_ADDR;
	int num_errors = 0, checked = 0, i;
	assign HREADY = HREADYOUT;
	always #2.5 MCLK = ~MCLK;
	bdrc_top i_bdrc_top (.*);
	bdrc_dma_host i_bdrc_dma_host (.*);

	// ==========
	// Tasks
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test;
		if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
		HSEL <= 1;
		HTRANS <= 2'h2;
		HADDR <= 32'(a);
		HWRITE <= w;
		do @(negedge MCLK); while (HREADYOUT !== 1);
		@(posedge MCLK);
		HSEL <= 0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		rd_ph <= !w;
		if (!w) eq.push_back(d);
		do @(negedge MCLK); while (HREADYOUT !== 1);
		@(posedge MCLK);
		rd_ph <= 0;
	endtask
	task automatic done(input logic [7:0] st, input logic [7:0] er);
		i = 0;
		do begin
			@(negedge MCLK);
			i++;
		end while (INTRQ !== 1 && i < 4000);
		chk("intrq", INTRQ, 1);
		@(posedge MCLK);
		ahb(bdrc_pkg::OFS_CMD, 0, st);
		ahb(bdrc_pkg::OFS_ERR, 0, er);
	endtask
	task automatic mrd(input logic [7:0] op, input logic l, input logic [7:0] sc,
			input bdrc_pkg::bdrc_addr_t a, input int n, input logic [1:0] fl);
		logic [15:0] w;
		ahb(bdrc_pkg::OFS_SN, 1, a.sn);
		ahb(bdrc_pkg::OFS_CL, 1, a.cl);
		ahb(bdrc_pkg::OFS_CH, 1, a.ch);
		ahb(bdrc_pkg::OFS_DH, 1, {1'b0, l, 2'b00, a.hd});
		ahb(bdrc_pkg::OFS_SC, 1, sc);
		ahb(bdrc_pkg::OFS_CMD, 1, op);
		do @(negedge MCLK); while (MEDIA_REQ !== 1);
		chk("media_addr", MEDIA_ADDR, a);
		chk("media_lba", MEDIA_LBA, l);
		@(posedge MCLK);
		repeat (n) begin
			w = 16'($urandom);
			MEDIA_DATA <= w;
			MEDIA_VALID <= 1;
			dq.push_back(w);
			do @(negedge MCLK); while (MEDIA_READY !== 1);
			@(posedge MCLK);
		end
		MEDIA_VALID <= 0;
		MEDIA_UNC <= fl[0];
		MEDIA_IDNF <= fl[1];
		@(posedge MCLK);
		MEDIA_UNC <= 0;
		MEDIA_IDNF <= 0;
	endtask

	// ==========
	// Result watcher
	always @(negedge MCLK) begin
		if (rd_ph) chk("hrdata", HRDATA, eq.pop_front());
		if (DMARQ && DMACK) chk("dma_data", DMA_DATA, dq.pop_front());
	end

	// ==========
	// Tests
	initial begin
		i = $urandom(94);
		repeat (4) @(posedge MCLK);
		RSTN <= 1;
		ahb(bdrc_pkg::OFS_CMD, 0, 8'h50);
		for (int k = 0; k < 256; k++) begin
			bw[k] = 16'($urandom);
			BUF_WR_EN <= 1;
			BUF_WR_ADDR <= 8'(k);
			BUF_WR_DATA <= bw[k];
			@(posedge MCLK);
		end
		BUF_WR_EN <= 0;
		foreach (bw[k]) dq.push_back(bw[k]);
		ahb(bdrc_pkg::OFS_CMD, 1, bdrc_pkg::OP_BUF_DMA);
		done(8'h50, 8'h00);
		ahb(bdrc_pkg::OFS_CMD, 1, bdrc_pkg::OP_BUF_PIO);
		repeat (20) @(posedge MCLK);
		foreach (bw[k]) ahb(bdrc_pkg::OFS_DATA, 0, bw[k]);
		done(8'h50, 8'h00);
		mrd(bdrc_pkg::OP_MED_DMA | 8'h01, 1, 8'h02, 28'h756_1234, 512, 2'b00);
		done(8'h50, 8'h00);
		ahb(bdrc_pkg::OFS_SC, 0, 8'h00);
		ahb(bdrc_pkg::OFS_SN, 0, 8'h35);
		ahb(bdrc_pkg::OFS_CL, 0, 8'h12);
		ahb(bdrc_pkg::OFS_CH, 0, 8'h56);
		ahb(bdrc_pkg::OFS_DH, 0, 8'h47);
		mrd(bdrc_pkg::OP_MED_DMA, 0, 8'h00, 28'h301_0205, 256, 2'b01);
		done(8'h51, 8'h40);
		ahb(bdrc_pkg::OFS_SC, 0, 8'hFF);
		ahb(bdrc_pkg::OFS_SN, 0, 8'h05);
		ahb(bdrc_pkg::OFS_CL, 0, 8'h02);
		ahb(bdrc_pkg::OFS_CH, 0, 8'h01);
		mrd(bdrc_pkg::OP_MED_DMA, 1, 8'h03, 28'h9AB_CDEF, 0, 2'b10);
		done(8'h51, 8'h10);
		ahb(bdrc_pkg::OFS_SC, 0, 8'h03);
		ahb(bdrc_pkg::OFS_SN, 0, 8'hEF);
		ahb(bdrc_pkg::OFS_CL, 0, 8'hCD);
		ahb(bdrc_pkg::OFS_CH, 0, 8'hAB);
		ahb(bdrc_pkg::OFS_DH, 0, 8'h49);
		ahb(bdrc_pkg::OFS_CMD, 1, 8'h00);
		done(8'h51, 8'h04);
		ahb(8'hE0, 0, 0);
		chk("host_left", eq.size(), 0);
		chk("dma_left", dq.size(), 0);
		end_of_test;
	end
	initial begin
		repeat (50000) @(posedge MCLK);
		num_errors++;
		end_of_test;
	end
endmodule

bind bdrc_top bdrc_properties i_bdrc_properties (.*);
